// ### qdrc_pkg.sv
// Shared constants and types for the quad converter register control link
`default_nettype none
// Overview of operation
// R1: Read select 01 working, 10 stored copy
// R2: Read target 0..3 picks converter code
// R3: Target 4 is control; 01/10/11 write, 00 transfers
// R4: Control bits 7:4 mute, 3:0 power down
// R5: Working control volatile, stored control survives power
// R6: Power up copies stored control to working
// R7: Stored control delivered as all zeros
// R8: Power-on reset loads every working register
// R9: Outputs held muted during initialisation interval
// R10: After initialisation apply loaded control and codes
// R11: Eight bit offset binary, MSB first
// R12: Code zero gives low reference, one step each
// R13: Unsupported select or target changes nothing
// R14: Read: write address, command 10, repeated start
// R15: Writes commit on 26th rising edge only
// R16: Code register access never clears mute or power down
// R17: Mute forces low reference, keeps code register
package qdrc_pkg;
    localparam int NUM_CONV = 4;
    localparam int CODE_W = 8;
    // Link framing
    localparam logic [2:0] ADDR_PREFIX = 3'h2;
    localparam int CMD_OP_LSB = 6;
    localparam int CMD_SEL_LSB = 4;
    localparam int CMD_TGT_LSB = 0;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] SEL_XFER = 2'h0;
    localparam logic [1:0] SEL_WORK = 2'h1;
    localparam logic [1:0] SEL_STORE = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
    localparam logic [3:0] TGT_CTRL = 4'h4;
    localparam logic [3:0] TGT_ALL = 4'hF;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Control register layout and reset values
    localparam int CTRL_MUTE_LSB = 4;
    localparam int CTRL_PD_LSB = 0;
    localparam logic [7:0] STORED_CTRL_RST = 8'h00;
    localparam logic [7:0] STORED_CODE_RST = 8'h00;
    localparam logic [7:0] LOW_REF_CODE = 8'h00;
    // Timing
    localparam int INIT_TIME_US = 500;
    localparam int LINK_HZ = 400_000;
    localparam int INIT_CYCLES = INIT_TIME_US * (LINK_HZ / 1000) / 1000;
    localparam int SYS_HZ = 50_000_000;
    localparam int SCL_QTR_CYCLES = SYS_HZ / (4 * LINK_HZ);
    // Controller registers on the Avalon-MM slave (byte offsets)
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_GO = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam int CMD_BYTE_LSB = 0;
    localparam int DATA_BYTE_LSB = 8;
    localparam int GO_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NACK_BIT = 1;
    localparam int ST_RDATA_LSB = 8;

    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_ADDR = 3'h1,
        DS_CMD = 3'h3,
        DS_DATA = 3'h2,
        DS_TX = 3'h6
    } qdrc_dev_state_e;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_START = 2'h1,
        HS_BIT = 2'h3,
        HS_STOP = 2'h2
    } qdrc_host_state_e;
endpackage
`default_nettype wire

// ### qdrc_link_if.sv
// Two-wire link between controller and converter device
`default_nettype none
interface qdrc_link_if;
    logic scl;
    logic host_sda_oe_n;
    logic dev_sda_oe_n;
    logic sda;
    // Open-drain data line with pull-up: low while either end drives
    assign sda = host_sda_oe_n & dev_sda_oe_n;
    modport host (output scl, output host_sda_oe_n, input sda);
    modport dev (input scl, input sda, output dev_sda_oe_n);
endinterface
`default_nettype wire

// ### qdrc_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`default_nettype none
module qdrc_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_in) begin
        meta_ff <= d_in;
        q_out <= meta_ff;
    end
endmodule
`default_nettype wire

// ### qdrc_device.sv
// Converter device end: link decoder, code and control registers, outputs
`default_nettype none
module qdrc_device #(
    parameter logic [3:0] DEV_ADDR = 4'h0,
    parameter int INIT_CYC = qdrc_pkg::INIT_CYCLES
) (
    qdrc_link_if.dev link,
    input wire logic rst_in,
    input wire logic nv_blank_in,
    output logic [qdrc_pkg::CODE_W-1:0] conv_level_out [qdrc_pkg::NUM_CONV],
    output logic [qdrc_pkg::NUM_CONV-1:0] conv_hiz_out,
    output logic init_busy_out
);
    import qdrc_pkg::*;

    localparam int ICW = $clog2(INIT_CYC + 1);

    logic [1:0] pins_s;
    logic por;
    logic blank;
    logic sda_rise_ff;
    logic start_ff;
    logic stop_ff;
    logic sda_oe_n_ff;
    qdrc_dev_state_e state_ff;
    logic [3:0] bitpos_ff;
    logic [7:0] rx_ff;
    logic [7:0] cmd_ff;
    logic [7:0] tx_ff;
    logic ack_ff;
    logic rd_armed_ff;
    logic [ICW-1:0] init_cnt_ff;
    logic [7:0] working_mute_powerdown_control_ff;
    logic [7:0] stored_mute_powerdown_control_ff;
    logic [7:0] working_code_register_ff [NUM_CONV];
    logic [7:0] stored_code_register_ff [NUM_CONV];
    logic [7:0] nxt_work_code [NUM_CONV];
    logic [7:0] nxt_stored_code [NUM_CONV];
    logic [7:0] nxt_level [NUM_CONV];
    logic [NUM_CONV-1:0] nxt_hiz;

    // Power-on reset and delivery-state strap arrive from outside the link domain
    qdrc_sync #(.W(2)) u_sync (
        .clk_in(link.scl),
        .d_in({nv_blank_in, rst_in}),
        .q_out(pins_s)
    );
    assign por = pins_s[0];
    assign blank = pins_s[1];

    // Byte assembly and command field decode
    wire [7:0] byte_in = {rx_ff[6:0], link.sda};
    wire byte_done = (bitpos_ff == BIT_LAST);
    wire [1:0] op = cmd_ff[CMD_OP_LSB +: 2];
    wire [1:0] sel = cmd_ff[CMD_SEL_LSB +: 2];
    wire [3:0] tgt = cmd_ff[CMD_TGT_LSB +: 4];
    wire addr_hit = (byte_in[7:1] == {ADDR_PREFIX, DEV_ADDR});
    wire tgt_dac = (tgt[3:2] == 2'b00);
    wire tgt_ctrl = (tgt == TGT_CTRL);
    wire tgt_all = (tgt == TGT_ALL) && (sel == SEL_WORK);
    wire wr_ok = (op == OP_WRITE) && (tgt_dac || tgt_ctrl || tgt_all); // R13
    wire rd_ok = (op == OP_READ) && tgt_dac && (sel == SEL_WORK || sel == SEL_STORE); // R13

    // Commit only on the rise that clocks in the last data bit
    wire commit = (state_ff == DS_DATA) && byte_done && wr_ok && !start_ff && !stop_ff; // R15
    wire wr_work = commit && (sel == SEL_WORK || sel == SEL_BOTH); // R3
    wire wr_store = commit && (sel == SEL_STORE || sel == SEL_BOTH); // R3
    wire xfer = commit && (sel == SEL_XFER); // R3

    // Read source: working or stored copy of the chosen converter
    wire [7:0] rd_byte = !rd_ok ? 8'h00 :
                         (sel == SEL_STORE) ? stored_code_register_ff[tgt[1:0]] : // R1 R2
                         working_code_register_ff[tgt[1:0]]; // R1 R2

    // Start and stop show as a data change while the clock is high
    always_ff @(negedge link.scl) begin
        if (por) begin
            start_ff <= 1'b0;
            stop_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else begin
            start_ff <= sda_rise_ff & ~link.sda;
            stop_ff <= ~sda_rise_ff & link.sda;
            // Ack pulls low; read data go out MSB first on the low phase
            sda_oe_n_ff <= ~(ack_ff | ((state_ff == DS_TX) && !bitpos_ff[3]
                              && !tx_ff[~bitpos_ff[2:0]])); // R11
        end
    end
    assign link.dev_sda_oe_n = sda_oe_n_ff;

    // Frame sequencer on the rising clock edge
    always_ff @(posedge link.scl) begin
        sda_rise_ff <= link.sda;
        if (por) begin
            state_ff <= DS_IDLE;
            bitpos_ff <= 4'h0;
            rx_ff <= 8'h00;
            cmd_ff <= 8'h00;
            tx_ff <= 8'h00;
            ack_ff <= 1'b0;
            rd_armed_ff <= 1'b0;
        end else if (start_ff) begin
            // This rise already carries the first address bit
            state_ff <= DS_ADDR;
            bitpos_ff <= 4'h1;
            rx_ff <= {7'h00, link.sda};
            ack_ff <= 1'b0;
        end else if (stop_ff) begin
            state_ff <= DS_IDLE;
            ack_ff <= 1'b0;
            rd_armed_ff <= 1'b0;
        end else if (state_ff != DS_IDLE) begin
            if (bitpos_ff == BIT_ACK) begin
                bitpos_ff <= 4'h0;
                ack_ff <= 1'b0;
                // Move on only after the ack slot, so the acked byte never ends the frame
                // One data byte per frame; a single read byte ends the answer
                case (state_ff)
                    DS_ADDR: begin
                        state_ff <= rx_ff[0] ? DS_TX : DS_CMD; // R14
                    end
                    DS_CMD: begin
                        state_ff <= DS_DATA;
                    end
                    default: begin
                        state_ff <= DS_IDLE;
                    end
                endcase
            end else begin
                rx_ff <= byte_in;
                bitpos_ff <= bitpos_ff + 4'h1;
                if (byte_done) begin
                    case (state_ff)
                        DS_ADDR: begin
                            if (addr_hit && !byte_in[0]) begin
                                ack_ff <= 1'b1;
                            end else if (addr_hit && rd_armed_ff) begin
                                ack_ff <= 1'b1; // R14
                                tx_ff <= rd_byte;
                            end else begin
                                state_ff <= DS_IDLE;
                            end
                        end
                        DS_CMD: begin
                            cmd_ff <= byte_in;
                            ack_ff <= 1'b1;
                            rd_armed_ff <= (byte_in[CMD_OP_LSB +: 2] == OP_READ); // R14
                        end
                        DS_DATA: begin
                            ack_ff <= 1'b1;
                        end
                        default: begin
                            ack_ff <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Control registers: stored copy survives power-on reset, working copy does not
    always_ff @(posedge link.scl) begin
        if (blank) begin
            stored_mute_powerdown_control_ff <= STORED_CTRL_RST; // R7
        end else if (wr_store && tgt_ctrl) begin
            stored_mute_powerdown_control_ff <= byte_in; // R5
        end
        if (por) begin
            working_mute_powerdown_control_ff <= stored_mute_powerdown_control_ff; // R6
        end else if (wr_work && tgt_ctrl) begin
            working_mute_powerdown_control_ff <= byte_in; // R3
        end else if (xfer && tgt_ctrl) begin
            working_mute_powerdown_control_ff <= stored_mute_powerdown_control_ff; // R3
        end
    end

    // Per-converter code registers and output stage
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
            wire hit = tgt_dac && (tgt[1:0] == 2'(gi));
            wire mute = working_mute_powerdown_control_ff[CTRL_MUTE_LSB + gi]; // R4
            wire pd = working_mute_powerdown_control_ff[CTRL_PD_LSB + gi]; // R4
            assign nxt_work_code[gi] = por ? stored_code_register_ff[gi] : // R8
                (wr_work && (hit || tgt_all)) ? byte_in :
                (xfer && hit) ? stored_code_register_ff[gi] :
                working_code_register_ff[gi];
            assign nxt_stored_code[gi] = blank ? STORED_CODE_RST :
                (wr_store && hit) ? byte_in : stored_code_register_ff[gi];
            // Mute wins over the code but leaves the register intact
            assign nxt_level[gi] = (init_busy_out || mute) ? LOW_REF_CODE : // R9 R17
                working_code_register_ff[gi]; // R11 R12
            // Power down applies only once initialisation has ended
            assign nxt_hiz[gi] = !init_busy_out && pd; // R10
        end
    endgenerate

    // Register banks and outputs clock on the same rise, outputs one link clock behind the banks; code register accesses never touch mute or pd
    always_ff @(posedge link.scl) begin
        working_code_register_ff <= nxt_work_code; // R16
        stored_code_register_ff <= nxt_stored_code;
        conv_level_out <= nxt_level; // R12
        conv_hiz_out <= nxt_hiz;
    end

    // Initialisation interval counted on the link clock
    always_ff @(posedge link.scl) begin
        if (por) begin
            init_cnt_ff <= ICW'(INIT_CYC); // R9
            init_busy_out <= 1'b1;
        end else begin
            if (init_cnt_ff != '0) begin
                init_cnt_ff <= init_cnt_ff - 1'b1;
            end
            init_busy_out <= (init_cnt_ff > ICW'(1)); // R10
        end
    end
endmodule
`default_nettype wire

// ### qdrc_host.sv
// Link controller end: Avalon-MM command registers and two-wire master
`default_nettype none
module qdrc_host #(
    parameter logic [3:0] DEV_ADDR = 4'h0,
    parameter int QTR = qdrc_pkg::SCL_QTR_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    qdrc_link_if.host link
);
    import qdrc_pkg::*;

    localparam int QW = $clog2(QTR + 1);

    qdrc_host_state_e state_ff;
    logic [QW-1:0] qcnt_ff;
    logic [1:0] phase_ff;
    logic scl_ff;
    logic rel_ff;
    logic [15:0] cmd_reg_ff;
    logic busy_ff;
    logic nack_ff;
    logic [7:0] rdata_ff;
    logic [1:0] bi_ff;
    logic [3:0] bitn_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic sda_s;

    // Data line comes from another clock's logic
    qdrc_sync #(.W(1)) u_sync (
        .clk_in(sys_clk_in),
        .d_in(link.sda),
        .q_out(sda_s)
    );

    // Bus decode; a write lands on the edge that sees waitrequest low
    wire acc = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    wire wr_cmd = acc && avs_write_in && (avs_address_in == OFS_CMD) && !busy_ff;
    wire wr_go = acc && avs_write_in && (avs_address_in == OFS_GO)
                 && avs_writedata_in[GO_BIT] && !busy_ff;
    wire [31:0] status = {16'h0000, rdata_ff, 6'h00, nack_ff, busy_ff};
    wire [31:0] rd_mux = (avs_address_in == OFS_CMD) ? {16'h0000, cmd_reg_ff} :
                         (avs_address_in == OFS_STATUS) ? status : 32'h0000_0000;

    // Frame contents
    wire [7:0] cmd_byte = cmd_reg_ff[CMD_BYTE_LSB +: 8];
    wire [7:0] data_byte = cmd_reg_ff[DATA_BYTE_LSB +: 8];
    wire is_read = (cmd_byte[CMD_OP_LSB +: 2] == OP_READ); // R1
    wire last = is_read ? (bi_ff == 2'h3) : (bi_ff == 2'h2);
    wire [1:0] bsel = (state_ff == HS_START) ? bi_ff : bi_ff + 2'h1;
    wire [7:0] byte_nxt = (bsel == 2'h0) ? {ADDR_PREFIX, DEV_ADDR, 1'b0} :
                          (bsel == 2'h1) ? cmd_byte :
                          (bsel == 2'h2) ? (is_read ? {ADDR_PREFIX, DEV_ADDR, 1'b1} // R14
                                                    : data_byte) : 8'hFF;
    wire tick = (qcnt_ff == QW'(QTR - 1));
    wire to_low = tick && (phase_ff == 2'h0); // data changes a quarter after fall
    wire to_mid = tick && (phase_ff == 2'h2); // sampling and start/stop, clock high

    // Avalon-MM slave: one wait cycle, then the answer
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= rd_mux;
            end
        end
    end

    // Command, status and result registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cmd_reg_ff <= 16'h0000;
            busy_ff <= 1'b0;
            nack_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            if (wr_cmd) begin
                cmd_reg_ff <= avs_writedata_in[15:0];
            end
            if (wr_go) begin
                busy_ff <= 1'b1;
            end else if (to_low && state_ff == HS_STOP) begin
                busy_ff <= 1'b0;
            end
            if (wr_go) begin
                nack_ff <= 1'b0;
            end else if (to_mid && state_ff == HS_BIT && bitn_ff == BIT_ACK && bi_ff != 2'h3) begin
                nack_ff <= sda_s;
            end
            if (to_mid && state_ff == HS_BIT && bitn_ff == BIT_ACK && bi_ff == 2'h3) begin
                rdata_ff <= rx_ff; // R11
            end
        end
    end

    // Free-running link clock from a quarter-period divider
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            qcnt_ff <= '0;
            phase_ff <= 2'h2;
            scl_ff <= 1'b1;
        end else begin
            qcnt_ff <= tick ? '0 : qcnt_ff + 1'b1;
            if (tick) begin
                phase_ff <= phase_ff + 2'h1;
                scl_ff <= phase_ff[0] ^ phase_ff[1];
            end
        end
    end
    assign link.scl = scl_ff;

    // Bit sequencer: one slot per link clock period
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_ff <= HS_IDLE;
            rel_ff <= 1'b1;
            bi_ff <= 2'h0;
            bitn_ff <= 4'h0;
            tx_ff <= 8'hFF;
            rx_ff <= 8'h00;
        end else if (to_low) begin
            case (state_ff)
                HS_IDLE: begin
                    if (busy_ff) begin
                        state_ff <= HS_START;
                        bi_ff <= 2'h0;
                        rel_ff <= 1'b1;
                    end
                end
                HS_START: begin
                    state_ff <= HS_BIT;
                    bitn_ff <= 4'h0;
                    tx_ff <= byte_nxt;
                    rel_ff <= byte_nxt[7]; // R11
                end
                HS_BIT: begin
                    if (bitn_ff < BIT_LAST) begin
                        bitn_ff <= bitn_ff + 4'h1;
                        tx_ff <= {tx_ff[6:0], 1'b1};
                        rel_ff <= tx_ff[6];
                    end else if (bitn_ff == BIT_LAST) begin
                        bitn_ff <= BIT_ACK; // ack slot, or master nack after read byte
                        rel_ff <= 1'b1;
                    end else if (nack_ff || last) begin
                        state_ff <= HS_STOP;
                        rel_ff <= 1'b0;
                    end else if (is_read && bi_ff == 2'h1) begin
                        state_ff <= HS_START; // R14
                        bi_ff <= 2'h2;
                        rel_ff <= 1'b1;
                    end else begin
                        bi_ff <= bi_ff + 2'h1;
                        bitn_ff <= 4'h0;
                        tx_ff <= byte_nxt;
                        rel_ff <= byte_nxt[7];
                    end
                end
                default: begin
                    state_ff <= HS_IDLE;
                end
            endcase
        end else if (to_mid) begin
            if (state_ff == HS_START) begin
                rel_ff <= 1'b0;
            end else if (state_ff == HS_STOP) begin
                rel_ff <= 1'b1;
            end else if (state_ff == HS_BIT && bitn_ff != BIT_ACK) begin
                rx_ff <= {rx_ff[6:0], sda_s};
            end
        end
    end
    assign link.host_sda_oe_n = rel_ff;
endmodule
`default_nettype wire

// ### qdrc_assertions.sv
// Concurrent checks on the two-wire link and the device outputs
`default_nettype none
module qdrc_assertions #(
    parameter int INIT_CYC = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic dev_rst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_oe_n,
    input wire logic [qdrc_pkg::CODE_W-1:0] conv_level_out [qdrc_pkg::NUM_CONV],
    input wire logic [qdrc_pkg::NUM_CONV-1:0] conv_hiz_out,
    input wire logic init_busy_out
);
    import qdrc_pkg::*;
    // Sync delay of the device reset adds a few edges to the interval
    localparam int INIT_MAX = INIT_CYC + 6;
    // Any converter off the low reference shows here
    wire logic [7:0] any_level = conv_level_out[0] | conv_level_out[1] |
        conv_level_out[2] | conv_level_out[3];
    a_dev_releases: assert property (@(posedge scl) disable iff (rst_in || dev_rst_in)
        !dev_sda_oe_n |-> ##[1:10] dev_sda_oe_n) else $error("device holds data line low");
    a_host_idle_rst: assert property (@(posedge sys_clk_in)
        rst_in [*2] |-> scl && host_sda_oe_n) else $error("host not idle in reset");
    a_dev_idle_rst: assert property (@(posedge scl) disable iff (rst_in)
        dev_rst_in [*4] |=> dev_sda_oe_n) else $error("device drives line in reset");
    a_dev_drive_low: assert property (@(posedge sys_clk_in) disable iff (rst_in || dev_rst_in)
        $changed(dev_sda_oe_n) |-> !scl) else $error("device changed data while clock high");
    a_init_muted: assert property (@(posedge scl) disable iff (dev_rst_in)
        init_busy_out |-> any_level == 8'h00) else $error("output not muted in init");
    a_init_no_pd: assert property (@(posedge scl) disable iff (dev_rst_in)
        init_busy_out |-> conv_hiz_out == 4'h0) else $error("power down during init");
    a_init_hold: assert property (@(posedge scl) disable iff (dev_rst_in)
        $fell(dev_rst_in) |-> init_busy_out [*8]) else $error("init interval too short");
    a_init_ends: assert property (@(posedge scl) disable iff (dev_rst_in)
        $fell(dev_rst_in) |-> ##[1:INIT_MAX] !init_busy_out) else $error("init never ends");
    // Main scenarios reached
    c_init_done: cover property (@(posedge scl) $fell(init_busy_out));
    c_dev_drive: cover property (@(posedge sys_clk_in) !dev_sda_oe_n);
    c_power_down: cover property (@(posedge scl) conv_hiz_out != 4'h0);
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench driving the controller registers and watching the device outputs
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import qdrc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic dev_rst = 1'b1;
    logic nv_blank = 1'b1;
    logic [3:0] av_addr = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic [7:0] lvl [NUM_CONV];
    logic [3:0] hiz;
    logic init_busy;
    logic [7:0] rb;
    logic [31:0] q;
    logic [7:0] bad [4] = '{8'h15, 8'h40, 8'h0F, 8'h2F};
    int n_mismatch = 0;
    int total_checks = 0;
    localparam logic [31:0] CODES = 32'hFF80_0100;
    qdrc_link_if qdrc_link_if_i ();
    qdrc_host #(.DEV_ADDR(4'h0), .QTR(2)) qdrc_host_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
        .avs_writedata_in(av_wd), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
        .link(qdrc_link_if_i));
    qdrc_device #(.DEV_ADDR(4'h0), .INIT_CYC(8)) qdrc_device_i (.link(qdrc_link_if_i),
        .rst_in(dev_rst), .nv_blank_in(nv_blank), .conv_level_out(lvl), .conv_hiz_out(hiz),
        .init_busy_out(init_busy));
    qdrc_assertions #(.INIT_CYC(8)) qdrc_assertions_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .dev_rst_in(dev_rst), .scl(qdrc_link_if_i.scl), .sda(qdrc_link_if_i.sda),
        .host_sda_oe_n(qdrc_link_if_i.host_sda_oe_n), .dev_sda_oe_n(qdrc_link_if_i.dev_sda_oe_n),
        .conv_level_out(lvl), .conv_hiz_out(hiz), .init_busy_out(init_busy));
    // 50 MHz system clock
    always #10 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access; waitrequest sampled at the rising edge, released only after it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        av_addr <= a;
        av_wd <= d;
        av_wr <= wr;
        av_rd <= !wr;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        if (n >= 50) n_mismatch++;
        q = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask
    // Whole link frame: load command, start it, poll until idle
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data);
        int n;
        n = 0;
        bus(1'b1, OFS_CMD, {16'h0000, data, cmd});
        bus(1'b1, OFS_GO, 32'h0000_0001);
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (q[ST_BUSY_BIT] !== 1'b0 && n < 1000);
        chk({7'h00, q[ST_NACK_BIT]}, 8'h00);
        rb = q[ST_RDATA_LSB +: 8];
    endtask
    task automatic lv(input logic [31:0] e);
        for (int i = 0; i < NUM_CONV; i++) chk(lvl[i], e[8*i +: 8]);
    endtask
    task automatic start_dev;
        int n;
        n = 0;
        dev_rst <= 1'b0;
        nv_blank <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        chk({7'h00, init_busy}, 8'h01);
        while (init_busy !== 1'b0 && n < 2000) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 2000) n_mismatch++;
        // Outputs take the loaded codes one link clock after init ends
        repeat (2) @(posedge qdrc_link_if_i.scl);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #1_500_000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (300) @(posedge sys_clk_in);
        start_dev();
        lv(32'h0);
        chk({4'h0, hiz}, 8'h00);
        $display("test init done");
        for (int k = 0; k < NUM_CONV; k++) frame({4'h1, k[3:0]}, CODES[8*k +: 8]);
        lv(CODES);
        for (int k = 0; k < NUM_CONV; k++) begin
            frame({4'h9, k[3:0]}, 8'h00);
            chk(rb, CODES[8*k +: 8]);
            frame({4'hA, k[3:0]}, 8'h00);
            chk(rb, 8'h00);
        end
        frame(8'h20, 8'h5A);
        lv(CODES);
        frame(8'hA0, 8'h00);
        chk(rb, 8'h5A);
        frame(8'h00, 8'h00);
        lv(32'hFF80_015A);
        $display("test codes done");
        frame(8'h14, 8'h84);
        lv(32'h0080_015A);
        chk({4'h0, hiz}, 8'h04);
        frame(8'h13, 8'h33);
        lv(32'h0080_015A);
        frame(8'h14, 8'h00);
        lv(32'h3380_015A);
        frame(8'h24, 8'hF0);
        lv(32'h3380_015A);
        frame(8'h04, 8'h00);
        lv(32'h0);
        frame(8'h34, 8'h0F);
        chk({4'h0, hiz}, 8'h0F);
        frame(8'h34, 8'h00);
        lv(32'h3380_015A);
        $display("test control done");
        foreach (bad[i]) frame(bad[i], 8'h77);
        lv(32'h3380_015A);
        chk({4'h0, hiz}, 8'h00);
        bus(1'b0, 4'hC, 32'h0);
        chk(q[7:0], 8'h00);
        frame(8'h1F, 8'h66);
        lv(32'h6666_6666);
        $display("test unsupported done");
        frame(8'h24, 8'h02);
        dev_rst <= 1'b1;
        repeat (100) @(posedge sys_clk_in);
        start_dev();
        lv(32'h0000_005A);
        chk({4'h0, hiz}, 8'h02);
        $display("test reload done");
        results();
    end
endmodule
`default_nettype wire
